// ### hw/postr_pkg.sv
// shared constants and types of the power-on self-test reporter
package postr_pkg;
  // clock and documented times
  localparam longint unsigned CLK_HZ = 64'd250000000;
  localparam longint unsigned LAMP_OFF_S = 64'd13;
  localparam longint unsigned PATTERN_END_S = 64'd4;
  localparam longint unsigned HOLD_MS = 64'd1000;
  localparam longint unsigned BLINK_MS = 64'd250;
  localparam longint unsigned SETTLE_CYC = 64'd3;
  // derived cycle counts (defaults of the top parameters)
  localparam longint unsigned LAMP_OFF_CYC_D = LAMP_OFF_S * CLK_HZ;
  localparam longint unsigned PAT_STEP_CYC_D = (PATTERN_END_S * CLK_HZ) / 64'd4;
  localparam longint unsigned HOLD_CYC_D = (HOLD_MS * CLK_HZ) / 64'd1000;
  localparam longint unsigned BLINK_CYC_D = (BLINK_MS * CLK_HZ) / 64'd1000;
  // front panel key positions on the key vector
  localparam int KEY_W = 24;
  localparam int KEY_WHITE_N = 16;
  localparam int KEY_BLACK_X = 16;
  localparam int KEY_BLACK_1 = 17;
  localparam int KEY_BLACK_0 = 18;
  localparam int KEY_CE = 19;
  // memory geometry
  localparam int RAM_AW = 15;
  localparam int RAM_DW = 8;
  localparam int RAM_DEV_AW = 11;
  localparam int ROM_AW = 15;
  localparam logic [ROM_AW-1:0] ROM_LAST = 15'h5fff;
  localparam int ROM_DEV_AW = 11;
  localparam int REC_AW = 10;
  localparam int REC_DW = 16;
  // display modes
  localparam logic [2:0] DISP_BRIGHT = 3'h1;
  localparam logic [2:0] DISP_BLANK = 3'h2;
  localparam logic [2:0] DISP_LINES = 3'h3;
  localparam logic [2:0] DISP_SHIFTED = 3'h4;
  localparam logic [2:0] DISP_STATUS = 3'h5;
  // status messages
  localparam logic [1:0] MSG_NONE = 2'h0;
  localparam logic [1:0] MSG_COMPLETE = 2'h1;
  localparam logic [1:0] MSG_ERROR = 2'h2;
  // sequencer states and failure kinds
  typedef enum {ST_KEYS, ST_KEY_STUCK, ST_RAM, ST_ROM, ST_REC, ST_WAIT_PASS,
    ST_PASS, ST_FAIL, ST_BYPASS} postr_state_t;
  typedef enum {FK_NONE, FK_RAM, FK_ROM, FK_REC} postr_fail_t;
endpackage

// ### hw/postr_march.sv
// write and read-back walker that exercises every bit of one memory
`timescale 1ns/1ns
`default_nettype none
module postr_march #(
  parameter int AW = 10,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic [AW-1:0] mem_addr,
  output logic [DW-1:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [DW-1:0] mem_rdata,
  output logic done,
  output logic fail,
  output logic [AW-1:0] fail_addr
);
  typedef enum {MW_IDLE, MW_WR, MW_RD, MW_WAIT, MW_CMP, MW_END} postr_mw_t;
  localparam logic [DW-1:0] CHK = {(DW/2){2'b10}};
  postr_mw_t state_ff, nxt_state;
  logic [AW-1:0] idx_ff, nxt_idx, addr_ff, nxt_addr, faddr_ff, nxt_faddr;
  logic [DW-1:0] wdata_ff, nxt_wdata, pat;
  logic we_ff, nxt_we, re_ff, nxt_re, pass_ff, nxt_pass;
  logic done_ff, nxt_done, fail_ff, nxt_fail;

  // checkerboard first, its inverse second, so each bit holds both values
  assign pat = pass_ff ? ~CHK : CHK;

  // walk: write all, read all (data valid one cycle after the read strobe)
  always_comb
  begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_we = 1'b0;
    nxt_re = 1'b0;
    nxt_pass = pass_ff;
    nxt_done = done_ff;
    nxt_fail = fail_ff;
    nxt_faddr = faddr_ff;
    case (state_ff)
      MW_IDLE:
      begin
        if (start)
        begin
          nxt_state = MW_WR;
          nxt_idx = '0;
          nxt_pass = 1'b0;
        end
      end
      MW_WR:
      begin
        nxt_addr = idx_ff;
        nxt_wdata = pat;
        nxt_we = 1'b1;
        nxt_idx = idx_ff + 1'b1;
        if (idx_ff == '1)
          nxt_state = MW_RD;
      end
      MW_RD:
      begin
        nxt_addr = idx_ff;
        nxt_re = 1'b1;
        nxt_state = MW_WAIT;
      end
      MW_WAIT: nxt_state = MW_CMP;
      MW_CMP:
      begin
        nxt_idx = idx_ff + 1'b1;
        if (mem_rdata != pat)
        begin
          nxt_fail = 1'b1; // mismatch ends the walk
          nxt_faddr = addr_ff;
          nxt_done = 1'b1;
          nxt_state = MW_END;
        end
        else if (idx_ff != '1)
          nxt_state = MW_RD;
        else if (pass_ff)
        begin
          nxt_done = 1'b1;
          nxt_state = MW_END;
        end
        else
        begin
          nxt_pass = 1'b1;
          nxt_state = MW_WR;
        end
      end
      MW_END: nxt_state = MW_END;
      default: nxt_state = MW_IDLE;
    endcase
  end

  // walker registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_ff <= MW_IDLE;
      idx_ff <= '0;
      addr_ff <= '0;
      wdata_ff <= '0;
      we_ff <= 1'b0;
      re_ff <= 1'b0;
      pass_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      faddr_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      we_ff <= nxt_we;
      re_ff <= nxt_re;
      pass_ff <= nxt_pass;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
      faddr_ff <= nxt_faddr;
    end
  end

  assign mem_addr = addr_ff;
  assign mem_wdata = wdata_ff;
  assign mem_we = we_ff;
  assign mem_re = re_ff;
  assign done = done_ff;
  assign fail = fail_ff;
  assign fail_addr = faddr_ff;
endmodule // postr_march
`default_nettype wire

// ### hw/postr_top.sv
// power-on self-test sequencer with error lamp and key interrogation
`timescale 1ns/1ns
`default_nettype none
module postr_top
  import postr_pkg::*;
#(
  parameter logic [31:0] LAMP_OFF_CYC = 32'(LAMP_OFF_CYC_D),
  parameter logic [31:0] PAT_STEP_CYC = 32'(PAT_STEP_CYC_D),
  parameter logic [31:0] HOLD_CYC = 32'(HOLD_CYC_D),
  parameter logic [31:0] BLINK_CYC = 32'(BLINK_CYC_D)
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [KEY_W-1:0] KEY_IN,
  output logic [RAM_AW-1:0] RAM_ADDR,
  output logic [RAM_DW-1:0] RAM_WDATA,
  output logic RAM_WE,
  output logic RAM_RE,
  input wire logic [RAM_DW-1:0] RAM_RDATA,
  output logic [ROM_AW-1:0] ROM_ADDR,
  output logic ROM_RE,
  input wire logic [7:0] ROM_RDATA,
  output logic [REC_AW-1:0] REC_ADDR,
  output logic [REC_DW-1:0] REC_WDATA,
  output logic REC_WE,
  output logic REC_RE,
  input wire logic [REC_DW-1:0] REC_RDATA,
  output logic ERR_LAMP,
  output logic [2:0] DISP_MODE,
  output logic [1:0] STATUS_MSG
);
  postr_state_t state_ff, nxt_state;
  postr_fail_t fkind_ff, nxt_fkind;
  logic [KEY_W-1:0] key_meta_ff, key_sync_ff, key_prev_ff;
  logic [31:0] elapsed_ff, nxt_elapsed, hold_ff, nxt_hold, blink_ff, nxt_blink;
  logic blink_ph_ff, nxt_blink_ph, lamp_ff, nxt_lamp;
  logic [2:0] disp_ff, nxt_disp;
  logic [1:0] msg_ff, nxt_msg;
  logic [3:0] fdev_ff, nxt_fdev;
  logic [ROM_AW-1:0] rom_idx_ff, nxt_rom_idx, rom_addr_ff, nxt_rom_addr;
  logic [1:0] rom_step_ff, nxt_rom_step;
  logic [7:0] rom_par_ff, nxt_rom_par;
  logic rom_re_ff, nxt_rom_re;
  logic ram_done, ram_fail, rec_done, rec_fail, any_key, one_key, held_long;
  logic [RAM_AW-1:0] ram_faddr;
  logic [REC_AW-1:0] rec_faddr;
  logic [KEY_W-1:0] key_minus1;
  logic dev_fault, rom_last_byte;

  // processor RAM walker
  postr_march #(.AW(RAM_AW), .DW(RAM_DW)) u_ram (
    .clk(MCLK),
    .rst_n(RST_N),
    .start(state_ff == ST_RAM),
    .mem_addr(RAM_ADDR),
    .mem_wdata(RAM_WDATA),
    .mem_we(RAM_WE),
    .mem_re(RAM_RE),
    .mem_rdata(RAM_RDATA),
    .done(ram_done),
    .fail(ram_fail),
    .fail_addr(ram_faddr)
  );

  // record memory walker
  postr_march #(.AW(REC_AW), .DW(REC_DW)) u_rec (
    .clk(MCLK),
    .rst_n(RST_N),
    .start(state_ff == ST_REC),
    .mem_addr(REC_ADDR),
    .mem_wdata(REC_WDATA),
    .mem_we(REC_WE),
    .mem_re(REC_RE),
    .mem_rdata(REC_RDATA),
    .done(rec_done),
    .fail(rec_fail),
    .fail_addr(rec_faddr)
  );

  // key pins pass two flip-flops; the previous sample tracks key changes
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      key_meta_ff <= '0;
      key_sync_ff <= '0;
      key_prev_ff <= '0;
    end
    else
    begin
      key_meta_ff <= KEY_IN;
      key_sync_ff <= key_meta_ff;
      key_prev_ff <= key_sync_ff;
    end
  end

  // key decode: any pressed, exactly one pressed, held unchanged long enough
  assign key_minus1 = key_sync_ff - 1'b1;
  assign any_key = |key_sync_ff;
  assign one_key = any_key && ((key_sync_ff & key_minus1) == '0);
  assign held_long = hold_ff >= HOLD_CYC;
  assign rom_last_byte = rom_idx_ff[ROM_DEV_AW-1:0] == '1;

  // interrogation: the pressed key points at the failure (no memory of it)
  always_comb
  begin
    dev_fault = 1'b0;
    if (one_key && (fkind_ff == FK_RAM || fkind_ff == FK_ROM))
    begin
      if (key_sync_ff[KEY_BLACK_X] && held_long)
        dev_fault = 1'b1;
      if (key_sync_ff[KEY_BLACK_1] && fkind_ff == FK_ROM)
        dev_fault = 1'b1;
      if (key_sync_ff[KEY_BLACK_0] && fkind_ff == FK_RAM)
        dev_fault = 1'b1;
      if (key_sync_ff[fdev_ff])
        dev_fault = 1'b1;
    end
  end

  // timers: elapsed since power-on, key hold, lamp blink phase
  always_comb
  begin
    nxt_elapsed = (elapsed_ff == '1) ? elapsed_ff : elapsed_ff + 32'h1;
    nxt_hold = (key_sync_ff != key_prev_ff || !any_key) ? 32'h0 :
      ((hold_ff == '1) ? hold_ff : hold_ff + 32'h1);
    nxt_blink = blink_ff + 32'h1;
    nxt_blink_ph = blink_ph_ff;
    if (blink_ff >= BLINK_CYC - 32'h1)
    begin
      nxt_blink = 32'h0;
      nxt_blink_ph = ~blink_ph_ff;
    end
  end

  // timer registers
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      elapsed_ff <= '0;
      hold_ff <= '0;
      blink_ff <= '0;
      blink_ph_ff <= 1'b0;
    end
    else
    begin
      elapsed_ff <= nxt_elapsed;
      hold_ff <= nxt_hold;
      blink_ff <= nxt_blink;
      blink_ph_ff <= nxt_blink_ph;
    end
  end

  // check sequencer with the ROM parity fold inline
  always_comb
  begin
    nxt_state = state_ff;
    nxt_fkind = fkind_ff;
    nxt_fdev = fdev_ff;
    nxt_rom_idx = rom_idx_ff;
    nxt_rom_addr = rom_addr_ff;
    nxt_rom_step = rom_step_ff;
    nxt_rom_par = rom_par_ff;
    nxt_rom_re = 1'b0;
    case (state_ff)
      ST_KEYS:
      begin
        if (elapsed_ff >= 32'(SETTLE_CYC))
          nxt_state = any_key ? ST_KEY_STUCK : ST_RAM;
      end
      ST_KEY_STUCK:
      begin
        if (!any_key)
          nxt_state = ST_RAM;
      end
      ST_RAM:
      begin
        if (ram_done && ram_fail)
        begin
          nxt_state = ST_FAIL;
          nxt_fkind = FK_RAM;
          nxt_fdev = ram_faddr[RAM_AW-1:RAM_DEV_AW];
        end
        else if (ram_done)
          nxt_state = ST_ROM;
      end
      ST_ROM:
      begin
        case (rom_step_ff)
          2'h0:
          begin
            nxt_rom_addr = rom_idx_ff;
            nxt_rom_re = 1'b1;
            nxt_rom_step = 2'h1;
          end
          2'h1: nxt_rom_step = 2'h2;
          default:
          begin
            nxt_rom_step = 2'h0;
            nxt_rom_idx = rom_idx_ff + 1'b1;
            nxt_rom_par = rom_last_byte ? 8'h00 : (rom_par_ff ^ ROM_RDATA);
            if (rom_last_byte && ROM_RDATA != rom_par_ff)
            begin
              nxt_state = ST_FAIL;
              nxt_fkind = FK_ROM;
              nxt_fdev = rom_idx_ff[ROM_AW-1:ROM_DEV_AW];
            end
            else if (rom_idx_ff == ROM_LAST)
              nxt_state = ST_REC;
          end
        endcase
      end
      ST_REC:
      begin
        if (rec_done)
        begin
          nxt_state = rec_fail ? ST_FAIL : ST_WAIT_PASS;
          nxt_fkind = rec_fail ? FK_REC : FK_NONE;
        end
      end
      ST_WAIT_PASS:
      begin
        if (elapsed_ff >= LAMP_OFF_CYC)
          nxt_state = ST_PASS;
      end
      ST_FAIL:
      begin
        if (one_key && key_sync_ff[KEY_CE] && held_long)
          nxt_state = ST_BYPASS;
      end
      ST_PASS: nxt_state = ST_PASS;
      ST_BYPASS: nxt_state = ST_BYPASS;
      default: nxt_state = ST_KEYS;
    endcase
  end

  // lamp, display and message follow the sequencer
  always_comb
  begin
    nxt_lamp = 1'b1;
    nxt_msg = MSG_NONE;
    if (elapsed_ff < PAT_STEP_CYC)
      nxt_disp = DISP_BRIGHT;
    else if (elapsed_ff < 32'(2) * PAT_STEP_CYC)
      nxt_disp = DISP_BLANK;
    else if (elapsed_ff < 32'(3) * PAT_STEP_CYC)
      nxt_disp = DISP_LINES;
    else
      nxt_disp = DISP_SHIFTED;
    case (state_ff)
      ST_KEY_STUCK: nxt_lamp = blink_ph_ff;
      ST_FAIL: nxt_lamp = dev_fault ? 1'b0 : blink_ph_ff;
      ST_PASS:
      begin
        nxt_lamp = 1'b0;
        nxt_disp = DISP_STATUS;
        nxt_msg = MSG_COMPLETE;
      end
      ST_BYPASS:
      begin
        nxt_lamp = 1'b0;
        nxt_disp = DISP_STATUS;
        nxt_msg = MSG_ERROR;
      end
      default: nxt_lamp = 1'b1;
    endcase
  end

  // sequencer and indicator registers
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      state_ff <= ST_KEYS;
      fkind_ff <= FK_NONE;
      fdev_ff <= '0;
      rom_idx_ff <= '0;
      rom_addr_ff <= '0;
      rom_step_ff <= '0;
      rom_par_ff <= '0;
      rom_re_ff <= 1'b0;
      lamp_ff <= 1'b1;
      disp_ff <= DISP_BRIGHT;
      msg_ff <= MSG_NONE;
    end
    else
    begin
      state_ff <= nxt_state;
      fkind_ff <= nxt_fkind;
      fdev_ff <= nxt_fdev;
      rom_idx_ff <= nxt_rom_idx;
      rom_addr_ff <= nxt_rom_addr;
      rom_step_ff <= nxt_rom_step;
      rom_par_ff <= nxt_rom_par;
      rom_re_ff <= nxt_rom_re;
      lamp_ff <= nxt_lamp;
      disp_ff <= nxt_disp;
      msg_ff <= nxt_msg;
    end
  end

  assign ROM_ADDR = rom_addr_ff;
  assign ROM_RE = rom_re_ff;
  assign ERR_LAMP = lamp_ff;
  assign DISP_MODE = disp_ff;
  assign STATUS_MSG = msg_ff;

  // checks on the sequencer
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_stuck_seen;
    state_ff == ST_KEYS && elapsed_ff >= 32'(SETTLE_CYC) && any_key;
  endsequence
  sequence s_ce_held;
    state_ff == ST_FAIL && one_key && key_sync_ff[KEY_CE] && held_long;
  endsequence
  key_scan_a: assert property (s_stuck_seen |=> state_ff == ST_KEY_STUCK)
    else $error("stuck key not reported");
  ram_fail_a: assert property (state_ff == ST_RAM && ram_done && ram_fail
    |=> state_ff == ST_FAIL && fkind_ff == FK_RAM) else $error("ram fault missed");
  rom_par_a: assert property (state_ff == ST_ROM && rom_step_ff == 2'h2 &&
    rom_last_byte && ROM_RDATA != rom_par_ff |=> fkind_ff == FK_ROM)
    else $error("rom parity fault missed");
  rec_fail_a: assert property (state_ff == ST_REC && rec_done && rec_fail
    |=> state_ff == ST_FAIL ##1 fkind_ff == FK_REC) else $error("record fault missed");
  lamp_run_a: assert property (state_ff inside {ST_RAM, ST_ROM, ST_REC}
    |=> ERR_LAMP) else $error("lamp dark during checks");
  disp_seq_a: assert property (elapsed_ff == PAT_STEP_CYC && state_ff != ST_PASS
    |=> DISP_MODE == DISP_BLANK) else $error("pattern order wrong");
  pass_off_a: assert property ($rose(state_ff == ST_PASS) |->
    $past(elapsed_ff) >= LAMP_OFF_CYC ##1 !ERR_LAMP && STATUS_MSG == MSG_COMPLETE)
    else $error("pass indication wrong");
  stuck_blink_a: assert property (state_ff == ST_KEY_STUCK && any_key
    |=> ERR_LAMP == $past(blink_ph_ff)) else $error("stuck key lamp not blinking");
  release_a: assert property (state_ff == ST_KEY_STUCK && !any_key
    |=> state_ff == ST_RAM ##1 ERR_LAMP) else $error("release not resumed");
  cross_dark_a: assert property (state_ff == ST_FAIL && fkind_ff inside {FK_RAM, FK_ROM} &&
    one_key && key_sync_ff[KEY_BLACK_X] && held_long |=> !ERR_LAMP)
    else $error("cross key did not darken lamp");
  class_dark_a: assert property (state_ff == ST_FAIL && fkind_ff == FK_RAM &&
    one_key && key_sync_ff[KEY_BLACK_0] |=> !ERR_LAMP) else $error("ram class key");
  ce_skip_a: assert property (s_ce_held |=> state_ff == ST_BYPASS ##1
    STATUS_MSG == MSG_ERROR && DISP_MODE == DISP_STATUS) else $error("bypass failed");
  order_a: assert property ($rose(state_ff == ST_ROM) |-> $past(state_ff) == ST_RAM)
    else $error("check order broken");
endmodule // postr_top
`default_nettype wire

// ### sim/postr_far_model.sv
// behavioural processor ram, burnt rom and record memory facing the self-test block
`timescale 1ns/1ns
`default_nettype none
module postr_far_model
  import postr_pkg::*;
(
  input wire logic clk,
  input wire logic [RAM_AW-1:0] ram_addr,
  input wire logic [RAM_DW-1:0] ram_wdata,
  input wire logic ram_we,
  input wire logic ram_re,
  output logic [RAM_DW-1:0] ram_rdata,
  input wire logic [ROM_AW-1:0] rom_addr,
  input wire logic rom_re,
  output logic [7:0] rom_rdata,
  input wire logic [REC_AW-1:0] rec_addr,
  input wire logic [REC_DW-1:0] rec_wdata,
  input wire logic rec_we,
  input wire logic rec_re,
  output logic [REC_DW-1:0] rec_rdata,
  input wire logic [RAM_AW-1:0] bad_addr,
  input wire logic [RAM_DW-1:0] bad_mask
);
  logic [RAM_DW-1:0] ram_mem_ff [0:32767];
  logic [7:0] rom_mem [0:24575];
  logic [REC_DW-1:0] rec_mem_ff [0:1023];
  logic rom_hold_ff;
  logic [7:0] parity;
  // rom image of twelve 2 KiB devices, each closed by its parity byte
  initial
  begin
    {ram_rdata, rom_rdata, rec_rdata, rom_hold_ff} = '0;
    for (int d = 0; d < 12; d++)
    begin
      parity = 8'h00;
      for (int i = 0; i < 2047; i++)
      begin
        rom_mem[d*2048+i] = 8'(d * 29 + i * 7 + (i >> 4));
        parity ^= rom_mem[d*2048+i];
      end
      rom_mem[d*2048+2047] = parity;
    end
  end
  // ram and record memory: data the cycle after the strobe, a toggling bus otherwise
  always @(posedge clk)
  begin
    if (ram_we)
      ram_mem_ff[ram_addr] <= ram_wdata;
    if (rec_we)
      rec_mem_ff[rec_addr] <= rec_wdata;
    if (ram_re)
      ram_rdata <= ram_mem_ff[ram_addr] ^ ((ram_addr == bad_addr) ? bad_mask : 8'h00);
    else
      ram_rdata <= ~ram_rdata;
    rec_rdata <= rec_re ? rec_mem_ff[rec_addr] : ~rec_rdata;
  end
  // rom keeps its byte two cycles after the strobe, then toggles
  always @(posedge clk)
  begin
    rom_hold_ff <= rom_re;
    if (rom_re)
      rom_rdata <= rom_mem[rom_addr];
    else if (!rom_hold_ff)
      rom_rdata <= ~rom_rdata;
  end
endmodule  // postr_far_model
`default_nettype wire

// ### sim/postr_top_test.sv
// self-checking bench of the power-on self-test reporter
`timescale 1ns/1ns
`default_nettype none
module postr_top_test
  import postr_pkg::*;
;
  localparam logic [31:0] LAMP_OFF = 32'h61a80;
  localparam logic [31:0] PSTEP = 32'h3e8;
  localparam logic [31:0] HOLD = 32'h32;
  localparam logic [31:0] BLINK = 32'h14;
  localparam int CEIL = 32'haae60;
  logic mclk, rst_n, ram_we, ram_re, rom_re, rec_we, rec_re, err_lamp;
  logic [KEY_W-1:0] key_in;
  logic [RAM_AW-1:0] ram_addr, bad_addr;
  logic [RAM_DW-1:0] ram_wdata, ram_rdata, bad_mask;
  logic [ROM_AW-1:0] rom_addr;
  logic [7:0] rom_rdata;
  logic [REC_AW-1:0] rec_addr;
  logic [REC_DW-1:0] rec_wdata, rec_rdata;
  logic [2:0] disp_mode;
  logic [1:0] status_msg;
  int bad_count, total_checks, tick, cyc, n_ram_wr, n_ram_rd, n_rom_rd, n_rec_wr, n_rec_rd;
  int ram_at_rom, rom_at_rec, ones, tog, dev, stuck;

  postr_top #(.LAMP_OFF_CYC(LAMP_OFF), .PAT_STEP_CYC(PSTEP), .HOLD_CYC(HOLD),
    .BLINK_CYC(BLINK)) i_postr_top (.MCLK(mclk), .RST_N(rst_n), .KEY_IN(key_in),
    .RAM_ADDR(ram_addr), .RAM_WDATA(ram_wdata), .RAM_WE(ram_we), .RAM_RE(ram_re),
    .RAM_RDATA(ram_rdata), .ROM_ADDR(rom_addr), .ROM_RE(rom_re), .ROM_RDATA(rom_rdata),
    .REC_ADDR(rec_addr), .REC_WDATA(rec_wdata), .REC_WE(rec_we), .REC_RE(rec_re),
    .REC_RDATA(rec_rdata), .ERR_LAMP(err_lamp), .DISP_MODE(disp_mode),
    .STATUS_MSG(status_msg));

  postr_far_model i_postr_far_model (.clk(mclk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata), .rom_addr(rom_addr),
    .rom_re(rom_re), .rom_rdata(rom_rdata), .rec_addr(rec_addr), .rec_wdata(rec_wdata),
    .rec_we(rec_we), .rec_re(rec_re), .rec_rdata(rec_rdata), .bad_addr(bad_addr),
    .bad_mask(bad_mask));

  // free-running clock
  initial
  begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end

  // elapsed time since power-on, memory traffic counts and the hang limit
  always @(posedge mclk)
  begin
    tick <= tick + 1;
    if (!rst_n)
      {cyc, n_ram_wr, n_ram_rd, n_rom_rd, n_rec_wr, n_rec_rd} <= '0;
    else
    begin
      cyc <= cyc + 1;
      n_ram_wr <= n_ram_wr + int'(ram_we);
      n_ram_rd <= n_ram_rd + int'(ram_re);
      n_rom_rd <= n_rom_rd + int'(rom_re);
      n_rec_wr <= n_rec_wr + int'(rec_we);
      n_rec_rd <= n_rec_rd + int'(rec_re);
      if (rom_re && n_rom_rd == 0)
        ram_at_rom <= n_ram_rd;  // ram traffic seen when rom starts
      if (rec_we && n_rec_wr == 0)
        rom_at_rec <= n_rom_rd;  // rom traffic seen when record memory starts
    end
    if (tick == CEIL)
    begin
      bad_count++;
      print_verdict();
    end
  end

  // verdict and end of run
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // compare seen against expected
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // wait n edges, then settle past the edge
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic press(input logic [KEY_W-1:0] v);
    step(1);
    key_in = v;
  endtask

  task automatic wait_to(input int n);
    while (cyc < n)
      step(1);
  endtask

  // count lit cycles and lamp changes over n cycles
  task automatic watch(input int n);
    logic last;
    ones = 0;
    tog = 0;
    last = err_lamp;
    repeat (n)
    begin
      step(1);
      ones += int'(err_lamp === 1'b1);
      tog += int'(err_lamp !== last);
      last = err_lamp;
    end
  endtask

  task automatic power_on(input logic [KEY_W-1:0] keys);
    rst_n = 0;
    key_in = keys;
    step(6);
    rst_n = 1;
  endtask

  // which single held key darkens the lamp on a ram fault in device d
  function automatic logic dark_key(input int k, input int d);
    return k == d || k == KEY_BLACK_X || k == KEY_BLACK_0;
  endfunction

  initial
  begin
    tick = 0;
    bad_count = 0;
    total_checks = 0;
    bad_addr = '0;
    bad_mask = '0;
    void'($urandom(29245));
    stuck = $urandom_range(0, 22);
    if (stuck >= KEY_BLACK_X)
      stuck++;
    // power on with one key held, cross key on top, then release
    power_on(24'h1 << stuck);
    step(10);
    watch(2 * BLINK + 4);
    chk("stuck_blink", tog > 0, 1);
    press(key_in | (24'h1 << KEY_BLACK_X));
    step(HOLD + 10);
    watch(2 * BLINK + 4);
    chk("cross_no_stop", tog > 0, 1);
    press('0);
    step(6);
    watch(100);
    chk("steady_release", ones, 100);
    // display patterns and a lit lamp while checks run
    for (int p = 0; p < 5; p++)
    begin
      wait_to(PSTEP * p + PSTEP / 2);
      chk("pattern", disp_mode, (p < 4) ? DISP_BRIGHT + p : DISP_SHIFTED);
      chk("lamp_lit", err_lamp, 1);
    end
    wait_to(32'h186a0);
    watch(200);
    chk("steady_midway", ones, 200);
    wait_to(LAMP_OFF - 20);
    chk("lamp_before", err_lamp, 1);
    chk("msg_before", status_msg, MSG_NONE);
    wait_to(LAMP_OFF + 20);
    chk("lamp_off", err_lamp, 0);
    chk("status_disp", disp_mode, DISP_STATUS);
    chk("status_msg", status_msg, MSG_COMPLETE);
    chk("ram_writes", n_ram_wr, 32'h10000);
    chk("ram_reads", n_ram_rd, 32'h10000);
    chk("rom_reads", n_rom_rd, 32'h6000);
    chk("rec_writes", n_rec_wr, 32'h800);
    chk("rec_reads", n_rec_rd, 32'h800);
    chk("ram_before_rom", ram_at_rom, 32'h10000);
    chk("rom_before_rec", rom_at_rec, 32'h6000);
    // second power-on with one flipped ram bit in a random device
    dev = $urandom_range(0, 14);
    bad_addr = RAM_AW'(dev * 2048 + $urandom_range(0, 15));
    bad_mask = 8'h1 << $urandom_range(0, 7);
    power_on('0);
    while (err_lamp === 1'b1 && cyc < 32'h249f0)
      step(1);
    chk("ram_fault_blink", err_lamp, 0);
    chk("stop_at_ram", n_rom_rd, 0);
    // every white key and the three black keys, one at a time
    for (int k = 0; k < 19; k++)
    begin
      press(24'h1 << k);
      step(HOLD + 6);
      watch(2 * BLINK + 4);
      chk("interrogate", dark_key(k, dev) ? ones : int'(tog > 0), dark_key(k, dev) ? 0 : 1);
      press('0);
      step(6);
      watch(2 * BLINK + 4);
      chk("no_latch", tog > 0, 1);
    end
    // operator holds clear-entry to bypass
    press(24'h1 << KEY_CE);
    step(HOLD + 10);
    chk("bypass_disp", disp_mode, DISP_STATUS);
    chk("bypass_msg", status_msg, MSG_ERROR);
    step(100);
    chk("rest_skipped", n_rom_rd + n_rec_wr, 0);
    press('0);
    print_verdict();
  end
endmodule  // postr_top_test
`default_nettype wire
